/* File: rtl/rsa_pkg.sv */
// Purpose: Shared constants and types of the RTC two-wire access port.
// Assumes: AXI4-Lite register window with 32-bit data, byte registers.
// Notes:   Real-time group 2 overlays the last three bytes of group 1.
package rsa_pkg;

  // Register window
  localparam int          AXI_AW        = 12;
  localparam logic [11:0] CTRL_OFS      = 12'h000;
  localparam logic [11:0] STAT_OFS      = 12'h004;
  localparam logic [11:0] DATA_OFS      = 12'h100;
  localparam int          CTRL_EN_BIT   = 4;
  localparam logic        CTRL_EN_RESET = 1'b1;
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_DECERR   = 2'b11;

  // Command field: group in the upper two bits, select bit below
  localparam logic [1:0]  GRP_STAT  = 2'b00;
  localparam logic [1:0]  GRP_RTIME = 2'b01;
  localparam logic [1:0]  GRP_INT   = 2'b10;
  localparam logic [1:0]  GRP_MISC  = 2'b11;

  // Byte store layout
  localparam int          MEM_WORDS = 17;
  localparam logic [4:0]  IDX_ST1   = 5'd0;
  localparam logic [4:0]  IDX_ST2   = 5'd1;
  localparam logic [4:0]  IDX_FIRST_IRQ_OUTPUT  = 5'd2;
  localparam logic [4:0]  IDX_SECOND_IRQ_OUTPUT  = 5'd5;
  localparam logic [4:0]  IDX_CORR  = 5'd8;
  localparam logic [4:0]  IDX_FREE  = 5'd9;
  localparam logic [4:0]  IDX_RT1   = 5'd10;
  localparam logic [4:0]  IDX_RT2   = 5'd14;

  // Byte counts per group
  localparam logic [3:0]  LEN_ONE   = 4'd1;
  localparam logic [3:0]  LEN_ALARM = 4'd3;
  localparam logic [3:0]  LEN_RT1   = 4'd7;
  localparam logic [3:0]  LEN_RT2   = 4'd3;

  // Output mode fields of the second status register
  localparam int          S2_FIRST_IRQ_OUTPUT_LSB = 5;
  localparam int          S2_SECOND_IRQ_OUTPUT_LSB = 1;
  localparam logic [2:0]  MODE_ALARM  = 3'b010;
  localparam logic [2:0]  MODE_FREQ   = 3'b100;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEVICE,
    ST_RX,
    ST_TX,
    ST_IGNORE
  } rsa_state_e;

  typedef struct packed {
    logic scl;
    logic sda;
  } rsa_line_s;

endpackage : rsa_pkg

/* File: rtl/rsa_serial_port.sv */
// Purpose: Two-wire serial slave front end of a real-time clock.
// Assumes: Bus lines arrive asynchronously and are oversampled by sys_clk.
// Notes:   Register bytes live here; timekeeping updates them over AXI.
`timescale 1ns/10ps

// How it works
// - Data falling while clock high starts an access.
// - Data rising while clock high stops the access, back to standby.
// - After start, everything moves in bytes, each with an acknowledge slot.
// - Data changes only while clock is low.
// - Data change during clock high aborts the ongoing byte transfer.
// - The receiving party acknowledges every received byte.
// - Master frees data after eighth clock; device pulls low on ninth.
// - No acknowledge when the access is irregular or code is wrong.
// - First byte holds device code, command, direction; one means read.
// - Read bytes leave most significant bit first, one per transfer.
// - Master continue acknowledge is low, final one is high.
// - Direction zero writes; device acknowledges each byte low; here bytes past the group length get no acknowledge.
// - Status command select bit picks first or second status register.
// - Interrupt command select bit picks first or second output register.
// - Interrupt registers are three bytes in alarm mode, else one.
// - No reset pin; only a stop returns the interface to idle; here resetn also returns it to idle.
// - Start and stop are ignored while the device drives data low.
module rsa_serial_port #(
  parameter logic [3:0] DEV_CODE = 4'b0110  // Arbitrary value
) (
  input  wire logic                       sys_clk,
  input  wire logic                       resetn,
  input  wire logic                       sclIn,
  input  wire logic                       sdaIn,
  output logic                            sdaOut,
  output logic                            sdaOe,
  input  wire logic [rsa_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [rsa_pkg::AXI_AW-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready
);

  // Line sampling: three stages, level accepted when stages two and three agree
  rsa_pkg::rsa_line_s s1_reg, s2_reg, s3_reg, line_reg, prev_reg;
  rsa_pkg::rsa_line_s lineNext;

  always_comb begin
    lineNext = (s2_reg == s3_reg) ? s3_reg : line_reg;
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s1_reg   <= '{scl: 1'b1, sda: 1'b1};
      s2_reg   <= '{scl: 1'b1, sda: 1'b1};
      s3_reg   <= '{scl: 1'b1, sda: 1'b1};
      line_reg <= '{scl: 1'b1, sda: 1'b1};
      prev_reg <= '{scl: 1'b1, sda: 1'b1};
    end else begin
      s1_reg   <= '{scl: sclIn, sda: sdaIn};
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      line_reg <= lineNext;
      prev_reg <= line_reg;
    end
  end

  logic sclRise, sclFall, startSeen, stopSeen;
  logic sdaOe_reg;

  // While we pull data low our own drive masks the line, so skip detection
  assign sclRise   = line_reg.scl & ~prev_reg.scl;
  assign sclFall   = ~line_reg.scl & prev_reg.scl;
  assign startSeen = line_reg.scl & prev_reg.scl & prev_reg.sda
                     & ~line_reg.sda & ~sdaOe_reg;
  assign stopSeen  = line_reg.scl & prev_reg.scl & ~prev_reg.sda
                     & line_reg.sda & ~sdaOe_reg;

  // Register bytes
  logic [7:0] mem [0:rsa_pkg::MEM_WORDS-1];
  logic [7:0] ctrl_reg;
  logic       memWe, axiMemWe;
  logic [4:0] memWaddr, axiMemAddr;
  logic [7:0] memWdata, axiMemData;

  // Protocol state
  rsa_pkg::rsa_state_e state_reg, stateNext;
  logic [3:0] bitCnt_reg, bitCntNext;
  logic [7:0] shift_reg, shiftNext;
  logic [2:0] cmd_reg, cmdNext;
  logic       rd_reg, rdNext;
  logic [2:0] idx_reg, idxNext;
  logic       oeNext;
  logic [7:0] acc_reg, accNext;
  logic       armed_reg, armedNext;
  logic [4:0] base;
  logic [3:0] len;
  logic [2:0] loadIdx;
  logic [7:0] loadByte;
  logic [2:0] intMode;

  // Group base and length; interrupt registers follow their output mode
  always_comb begin
    intMode = cmd_reg[0] ? mem[rsa_pkg::IDX_ST2][rsa_pkg::S2_SECOND_IRQ_OUTPUT_LSB +: 3]
                         : mem[rsa_pkg::IDX_ST2][rsa_pkg::S2_FIRST_IRQ_OUTPUT_LSB +: 3];
    base = rsa_pkg::IDX_ST1;
    len  = rsa_pkg::LEN_ONE;
    unique case (cmd_reg[2:1])
      rsa_pkg::GRP_STAT: begin
        base = cmd_reg[0] ? rsa_pkg::IDX_ST2 : rsa_pkg::IDX_ST1;
      end
      rsa_pkg::GRP_RTIME: begin
        base = cmd_reg[0] ? rsa_pkg::IDX_RT2 : rsa_pkg::IDX_RT1;
        len  = cmd_reg[0] ? rsa_pkg::LEN_RT2 : rsa_pkg::LEN_RT1;
      end
      rsa_pkg::GRP_INT: begin
        base = cmd_reg[0] ? rsa_pkg::IDX_SECOND_IRQ_OUTPUT : rsa_pkg::IDX_FIRST_IRQ_OUTPUT;
        len  = (intMode == rsa_pkg::MODE_ALARM) ? rsa_pkg::LEN_ALARM
                                                : rsa_pkg::LEN_ONE;
      end
      rsa_pkg::GRP_MISC: begin
        base = cmd_reg[0] ? rsa_pkg::IDX_FREE : rsa_pkg::IDX_CORR;
      end
    endcase
  end

  always_comb begin
    stateNext = state_reg;
    bitCntNext = bitCnt_reg;
    shiftNext = shift_reg;
    cmdNext = cmd_reg;
    rdNext = rd_reg;
    idxNext = idx_reg;
    oeNext = sdaOe_reg;
    accNext = acc_reg;
    armedNext = armed_reg;
    memWe = 1'b0;
    memWaddr = base + {2'b00, idx_reg};
    memWdata = shift_reg;
    loadIdx = (state_reg == rsa_pkg::ST_DEVICE) ? 3'd0 : idx_reg + 3'd1;
    // Past the end of the group the device only sends released ones
    loadByte = ({1'b0, loadIdx} < len)
               ? mem[base + {2'b00, loadIdx}] : 8'hFF;
    if (stopSeen) begin
      stateNext = rsa_pkg::ST_IDLE;
      oeNext = 1'b0;
      if (state_reg != rsa_pkg::ST_IDLE) begin
        accNext = acc_reg + 8'd1;
      end
    end else if (startSeen) begin
      stateNext = rsa_pkg::ST_DEVICE;
      bitCntNext = 4'd0;
      idxNext = 3'd0;
      oeNext = 1'b0;
      armedNext = 1'b0;
    end else if (state_reg != rsa_pkg::ST_IDLE &&
                 state_reg != rsa_pkg::ST_IGNORE) begin
      if (sclRise && bitCnt_reg < 4'd8 && state_reg != rsa_pkg::ST_TX) begin
        shiftNext = {shift_reg[6:0], line_reg.sda};
      end
      // High in the master's slot ends the read
      if (sclRise && bitCnt_reg == 4'd8 && state_reg == rsa_pkg::ST_TX &&
          line_reg.sda) begin
        stateNext = rsa_pkg::ST_IGNORE;
      end
      if (sclRise) begin
        armedNext = 1'b1;
      end
      // The clock fall that closes a start carries no bit
      if (sclFall && armed_reg) begin
        if (bitCnt_reg < 4'd7) begin
          bitCntNext = bitCnt_reg + 4'd1;
          if (state_reg == rsa_pkg::ST_TX) begin
            shiftNext = {shift_reg[6:0], 1'b1};
            oeNext = ~shift_reg[6];
          end
        end else if (bitCnt_reg == 4'd7) begin
          bitCntNext = 4'd8;
          oeNext = 1'b0;  // Master answers in the slot of a read byte
          if (state_reg == rsa_pkg::ST_DEVICE) begin
            if (ctrl_reg[rsa_pkg::CTRL_EN_BIT] &&
                shift_reg[7:4] == DEV_CODE) begin
              oeNext = 1'b1;
              cmdNext = shift_reg[3:1];
              rdNext = shift_reg[0];
            end else begin
              stateNext = rsa_pkg::ST_IGNORE;
            end
          end else if (state_reg == rsa_pkg::ST_RX) begin
            if ({1'b0, idx_reg} < len) begin
              oeNext = 1'b1;
              memWe = 1'b1;
            end else begin
              stateNext = rsa_pkg::ST_IGNORE;
            end
          end
        end else begin
          bitCntNext = 4'd0;
          oeNext = 1'b0;
          if (state_reg == rsa_pkg::ST_RX) begin
            idxNext = idx_reg + 3'd1;
          end else if (state_reg == rsa_pkg::ST_TX ||
                       (state_reg == rsa_pkg::ST_DEVICE && rd_reg)) begin
            stateNext = rsa_pkg::ST_TX;
            idxNext = loadIdx;
            shiftNext = loadByte;
            oeNext = ~loadByte[7];
          end else begin
            stateNext = rsa_pkg::ST_RX;
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_reg  <= rsa_pkg::ST_IDLE;
      bitCnt_reg <= 4'd0;
      shift_reg  <= 8'h00;
      cmd_reg    <= 3'd0;
      rd_reg     <= 1'b0;
      idx_reg    <= 3'd0;
      sdaOe_reg  <= 1'b0;
      acc_reg    <= 8'h00;
      armed_reg  <= 1'b0;
    end else begin
      state_reg  <= stateNext;
      bitCnt_reg <= bitCntNext;
      shift_reg  <= shiftNext;
      cmd_reg    <= cmdNext;
      rd_reg     <= rdNext;
      idx_reg    <= idxNext;
      sdaOe_reg  <= oeNext;
      acc_reg    <= accNext;
      armed_reg  <= armedNext;
    end
  end

  // Byte store: the serial side wins a same-cycle collision
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      for (int i = 0; i < rsa_pkg::MEM_WORDS; i++) begin
        mem[i] <= 8'h00;
      end
    end else if (memWe) begin
      mem[memWaddr] <= memWdata;
    end else if (axiMemWe) begin
      mem[axiMemAddr] <= axiMemData;
    end
  end

  // AXI4-Lite slave
  logic        awHeld_reg, awHeldNext, wHeld_reg, wHeldNext;
  logic [11:0] awAddr_reg, awAddrNext;
  logic [31:0] wData_reg, wDataNext;
  logic        wStrb0_reg, wStrb0Next;
  logic        awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic        bvalidNext, arreadyNext, rvalidNext;
  logic [1:0]  bresp_reg, brespNext, rresp_reg, rrespNext;
  logic [31:0] rdata_reg, rdataNext;
  logic [7:0]  ctrlNext;
  logic [11:0] wOff, rOff;
  logic        sdaOut_reg;

  always_comb begin
    awHeldNext = awHeld_reg | (s_axi_awvalid & awready_reg);
    awAddrNext = (s_axi_awvalid & awready_reg) ? s_axi_awaddr : awAddr_reg;
    wHeldNext  = wHeld_reg | (s_axi_wvalid & wready_reg);
    wDataNext  = (s_axi_wvalid & wready_reg) ? s_axi_wdata : wData_reg;
    wStrb0Next = (s_axi_wvalid & wready_reg) ? s_axi_wstrb[0] : wStrb0_reg;
    bvalidNext = bvalid_reg & ~s_axi_bready;
    brespNext  = bresp_reg;
    ctrlNext   = ctrl_reg;
    axiMemWe   = 1'b0;
    wOff       = awAddr_reg - rsa_pkg::DATA_OFS;
    axiMemAddr = wOff[6:2];
    axiMemData = wData_reg[7:0];
    if (awHeld_reg && wHeld_reg && !bvalid_reg) begin
      awHeldNext = 1'b0;
      wHeldNext  = 1'b0;
      bvalidNext = 1'b1;
      brespNext  = rsa_pkg::RESP_OKAY;
      if (awAddr_reg[11:2] == rsa_pkg::CTRL_OFS[11:2]) begin
        if (wStrb0_reg) begin
          ctrlNext = wData_reg[7:0];
        end
      end else if (awAddr_reg >= rsa_pkg::DATA_OFS &&
                   wOff[11:2] < 10'(rsa_pkg::MEM_WORDS)) begin
        axiMemWe = wStrb0_reg;
      end else if (awAddr_reg[11:2] != rsa_pkg::STAT_OFS[11:2]) begin
        brespNext = rsa_pkg::RESP_DECERR;
      end
    end
    rvalidNext  = rvalid_reg & ~s_axi_rready;
    arreadyNext = ~rvalidNext;
    rdataNext   = rdata_reg;
    rrespNext   = rresp_reg;
    rOff        = s_axi_araddr - rsa_pkg::DATA_OFS;
    if (s_axi_arvalid && arready_reg) begin
      rvalidNext  = 1'b1;
      arreadyNext = 1'b0;
      rrespNext   = rsa_pkg::RESP_OKAY;
      rdataNext   = 32'h0000_0000;
      if (s_axi_araddr[11:2] == rsa_pkg::CTRL_OFS[11:2]) begin
        rdataNext[7:0] = ctrl_reg;
      end else if (s_axi_araddr[11:2] == rsa_pkg::STAT_OFS[11:2]) begin
        rdataNext[15:0] = {acc_reg, 1'b0,
                           state_reg == rsa_pkg::ST_IGNORE, sdaOe_reg,
                           cmd_reg, rd_reg, state_reg != rsa_pkg::ST_IDLE};
      end else if (s_axi_araddr >= rsa_pkg::DATA_OFS &&
                   rOff[11:2] < 10'(rsa_pkg::MEM_WORDS)) begin
        rdataNext[7:0] = mem[rOff[6:2]];
      end else begin
        rrespNext = rsa_pkg::RESP_DECERR;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      awHeld_reg  <= 1'b0;
      awAddr_reg  <= 12'h000;
      wHeld_reg   <= 1'b0;
      wData_reg   <= 32'h0000_0000;
      wStrb0_reg  <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= 2'b00;
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= 2'b00;
      ctrl_reg    <= {3'b000, rsa_pkg::CTRL_EN_RESET, DEV_CODE};
      sdaOut_reg  <= 1'b0;
    end else begin
      awHeld_reg  <= awHeldNext;
      awAddr_reg  <= awAddrNext;
      wHeld_reg   <= wHeldNext;
      wData_reg   <= wDataNext;
      wStrb0_reg  <= wStrb0Next;
      awready_reg <= ~awHeldNext;
      wready_reg  <= ~wHeldNext;
      bvalid_reg  <= bvalidNext;
      bresp_reg   <= brespNext;
      arready_reg <= arreadyNext;
      rvalid_reg  <= rvalidNext;
      rdata_reg   <= rdataNext;
      rresp_reg   <= rrespNext;
      ctrl_reg    <= ctrlNext;
      sdaOut_reg  <= 1'b0;  // Open drain: only ever pulls low
    end
  end

  assign sdaOut        = sdaOut_reg;
  assign sdaOe         = sdaOe_reg;
  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  a_start_enters_dev: assert property (startSeen && !stopSeen |=>
    state_reg == rsa_pkg::ST_DEVICE && bitCnt_reg == 4'd0)
    else $error("start did not open an access");
  a_stop_goes_idle: assert property (stopSeen |=>
    state_reg == rsa_pkg::ST_IDLE && !sdaOe_reg)
    else $error("stop did not return to idle");
  a_bit_count_range: assert property (bitCnt_reg <= 4'd8)
    else $error("bit counter left the byte frame");
  a_drive_on_fall: assert property ($changed(sdaOe_reg) &&
    !$past(stopSeen) && !$past(startSeen) |-> $past(sclFall))
    else $error("data drive changed outside a clock fall");
  a_ack_in_ninth: assert property (sclFall && bitCnt_reg == 4'd7 &&
    state_reg == rsa_pkg::ST_RX && {1'b0, idx_reg} < len && !stopSeen &&
    !startSeen |=> sdaOe_reg && bitCnt_reg == 4'd8)
    else $error("write byte not acknowledged in slot nine");
  a_bad_code_nack: assert property (sclFall && bitCnt_reg == 4'd7 &&
    state_reg == rsa_pkg::ST_DEVICE && shift_reg[7:4] != DEV_CODE &&
    !stopSeen && !startSeen |=> state_reg == rsa_pkg::ST_IGNORE ##0
    !sdaOe_reg [*2])
    else $error("foreign device code was acknowledged");
  a_read_mode_entry: assert property (sclFall && bitCnt_reg == 4'd8 &&
    state_reg == rsa_pkg::ST_DEVICE && rd_reg && !stopSeen && !startSeen
    |=> state_reg == rsa_pkg::ST_TX && sdaOe_reg == ~shift_reg[7])
    else $error("read direction did not start sending");
  a_msb_first: assert property (state_reg == rsa_pkg::ST_TX &&
    sclFall && bitCnt_reg < 4'd7 && !stopSeen && !startSeen |=>
    sdaOe_reg == ~$past(shift_reg[6]))
    else $error("read bit order broken");
  a_drive_blocks_stop: assert property (sdaOe_reg &&
    state_reg != rsa_pkg::ST_IDLE |=> state_reg != rsa_pkg::ST_IDLE)
    else $error("stop accepted while pulling data low");
  a_ignore_released: assert property (state_reg == rsa_pkg::ST_IGNORE
    |-> !sdaOe_reg)
    else $error("device drives data after abandoning access");

endmodule : rsa_serial_port

/* File: bench/rsa_i2c_master.sv */
// Purpose: Behavioural two-wire bus master driving the access port.
// Assumes: Open-drain data line with pull-up; 8 sys_clk per bus bit.
// Notes:   Bus clock stands high between frames, it never runs free.
`timescale 1ns/10ps
module rsa_i2c_master (
  input  wire logic       sys_clk,
  input  wire logic       sdaLine,
  output logic            scl,
  output logic            sdaLow,
  output logic            serDone,
  output logic [8:0]      serVal
);
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
    serDone = 1'b0;
    serVal = '0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  // Start when st is high, stop otherwise; data settles before clock rises
  task automatic cond(input logic st);
    tick(2);
    sdaLow <= ~st;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sdaLow <= st;
    tick(4);
    scl <= ~st;
  endtask : cond
  // Data moves two cycles after the fall, clear of the hold margin
  task automatic clk_bit(input logic b, output logic s);
    tick(2);
    sdaLow <= ~b;
    tick(2);
    scl <= 1'b1;
    tick(3);
    s = sdaLine;
    tick(1);
    scl <= 1'b0;
  endtask : clk_bit
  // An ack input of one leaves the line free for the device
  task automatic xfer(input logic [7:0] tx, input logic ackIn,
                      output logic [7:0] rx, output logic ackOut);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(tx[i], rx[i]);
    end
    clk_bit(ackIn, ackOut);
    serVal <= {ackOut, rx};
    serDone <= 1'b1;
    tick(1);
    serDone <= 1'b0;
  endtask : xfer
  task automatic recover();
    logic s;
    cond(1'b1);
    for (int i = 0; i < 63; i++) begin
      clk_bit(1'b1, s);
    end
    cond(1'b0);
  endtask : recover
endmodule : rsa_i2c_master

/* File: bench/rtc_serial_access_port_bench.sv */
// Purpose: Self-checking bench of the RTC two-wire access port.
// Assumes: AXI4-Lite master tasks here, bus master in rsa_i2c_master.
// Notes:   Drivers queue expected results; a monitor checks in order.
`timescale 1ns/10ps
module rtc_serial_access_port_bench;
  localparam logic [3:0]  CODE = 4'b0110;  // Arbitrary value
  localparam logic [33:0] ALL  = '1;
  logic        sys_clk = 1'b0, resetn = 1'b0;
  logic        awValid = 1'b0, wValid = 1'b0, bReady = 1'b0;
  logic        arValid = 1'b0, rReady = 1'b0;
  logic [11:0] awAddr = '0, arAddr = '0;
  logic [31:0] wData = '0, seed = 32'h46fd_ccdd, rData;
  logic        awReady, wReady, bValid, arReady, rValid;
  logic        sdaOut, sdaOe, scl, sdaLow, serDone;
  logic [1:0]  bResp, rResp;
  logic [8:0]  serVal;
  wire logic   sdaLine;
  logic [33:0] aQ [$], mQ [$];
  logic [8:0]  sQ [$];
  int          numErrors = 0, cmpCount = 0, cyc = 0;
  // Pull-up wins whenever nobody pulls low
  assign sdaLine = ~(sdaLow | (sdaOe & ~sdaOut));
  rsa_serial_port #(.DEV_CODE(CODE)) i_rsa_serial_port (
    .sys_clk(sys_clk), .resetn(resetn), .sclIn(scl), .sdaIn(sdaLine),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady));
  rsa_i2c_master i_rsa_i2c_master (.sys_clk(sys_clk), .sdaLine(sdaLine),
    .scl(scl), .sdaLow(sdaLow), .serDone(serDone), .serVal(serVal));
  always #12.5 sys_clk = ~sys_clk;
  task automatic end_of_test();
    if (numErrors == 0 && cmpCount > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      numErrors++;
      end_of_test();
    end
  end
  task automatic cmp_axi(input logic [33:0] g, e, m);
    cmpCount++;
    if ((g & m) !== (e & m)) begin
      numErrors++;
      $display("wrong value at %0t: %h vs %h", $time, g & m, e & m);
    end
  endtask : cmp_axi
  task automatic cmp_ser(input logic [8:0] g, e);
    cmpCount++;
    if (g !== e) begin
      numErrors++;
      $display("wrong value at %0t: %h vs %h", $time, g, e);
    end
  endtask : cmp_ser
  always @(posedge sys_clk) begin
    if (rValid && rReady)
      cmp_axi({rResp, rData}, aQ.pop_front(), mQ.pop_front());
    if (bValid && bReady)
      cmp_axi({bResp, 32'h0}, aQ.pop_front(), mQ.pop_front());
    if (serDone)
      cmp_ser(serVal, sQ.pop_front());
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                        input logic [1:0] e);
    logic aw, w;
    aQ.push_back({e, 32'h0});
    mQ.push_back({2'b11, 32'h0});
    aw = 1'b0;
    w = 1'b0;
    @(posedge sys_clk);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    while (!(aw && w)) begin
      @(posedge sys_clk);
      if (awValid && awReady) begin
        aw = 1'b1;
        awValid <= 1'b0;
      end
      if (wValid && wReady) begin
        w = 1'b1;
        wValid <= 1'b0;
      end
    end
    do @(posedge sys_clk); while (bValid !== 1'b1);
    bReady <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [11:0] a, input logic [33:0] e, m);
    aQ.push_back(e);
    mQ.push_back(m);
    @(posedge sys_clk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do @(posedge sys_clk); while (!(arValid && arReady));
    arValid <= 1'b0;
    do @(posedge sys_clk); while (rValid !== 1'b1);
    rReady <= 1'b0;
  endtask : axi_rd
  task automatic rdb(input logic [4:0] i, input logic [7:0] v);
    axi_rd(rsa_pkg::DATA_OFS + 12'({i, 2'b00}), {26'h0, v}, ALL);
  endtask : rdb
  task automatic wrb(input logic [4:0] i, input logic [7:0] v);
    axi_wr(rsa_pkg::DATA_OFS + 12'({i, 2'b00}), {24'h0, v},
           rsa_pkg::RESP_OKAY);
  endtask : wrb
  // Device byte: code, group, select, direction
  function automatic logic [7:0] dev(input logic [1:0] g,
                                     input logic sl, rw);
    return {CODE, g, sl, rw};
  endfunction : dev
  task automatic bus(input logic st);
    i_rsa_i2c_master.cond(st);
  endtask : bus
  task automatic ser(input logic [7:0] v, input logic ack, rd);
    logic [7:0] r;
    logic       a;
    sQ.push_back({ack, v});
    i_rsa_i2c_master.xfer(rd ? 8'hff : v, rd ? ack : 1'b1, r, a);
  endtask : ser
  initial begin
    logic [7:0] b [6];
    logic       s;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;  // Serial lines stay quiet well after start-up
    for (int i = 0; i < 6; i++) b[i] = 8'(rnd());
    axi_rd(rsa_pkg::CTRL_OFS, {29'h0, rsa_pkg::CTRL_EN_RESET, CODE}, ALL);
    axi_rd(rsa_pkg::STAT_OFS, '0, ALL);
    axi_rd(12'hffc, {rsa_pkg::RESP_DECERR, 32'h0}, ALL);
    axi_wr(12'hff8, rnd(), rsa_pkg::RESP_DECERR);
    axi_wr(rsa_pkg::STAT_OFS, rnd(), rsa_pkg::RESP_OKAY);
    axi_rd(rsa_pkg::STAT_OFS, '0, ALL);
    bus(1'b1);
    ser(dev(rsa_pkg::GRP_STAT, 1'b1, 1'b0), 1'b0, 1'b0);
    ser(rsa_pkg::MODE_ALARM << rsa_pkg::S2_FIRST_IRQ_OUTPUT_LSB, 1'b0, 1'b0);
    bus(1'b0);
    rdb(rsa_pkg::IDX_ST2, 8'h40);
    rdb(rsa_pkg::IDX_ST1, 8'h00);
    axi_rd(rsa_pkg::STAT_OFS, 34'h0_0000_0100, 34'h0_0000_ff41);
    bus(1'b1);
    ser(dev(rsa_pkg::GRP_INT, 1'b0, 1'b0), 1'b0, 1'b0);
    for (int i = 0; i < 3; i++) ser(b[i], 1'b0, 1'b0);
    ser(b[3], 1'b1, 1'b0);
    bus(1'b0);
    for (int i = 0; i < 3; i++) rdb(rsa_pkg::IDX_FIRST_IRQ_OUTPUT + 5'(i), b[i]);
    bus(1'b1);
    ser(dev(rsa_pkg::GRP_INT, 1'b1, 1'b0), 1'b0, 1'b0);
    ser(b[3], 1'b0, 1'b0);
    ser(b[4], 1'b1, 1'b0);
    bus(1'b0);
    rdb(rsa_pkg::IDX_SECOND_IRQ_OUTPUT, b[3]);
    rdb(rsa_pkg::IDX_SECOND_IRQ_OUTPUT + 5'd1, 8'h00);
    wrb(rsa_pkg::IDX_CORR, b[4]);
    wrb(rsa_pkg::IDX_FREE, b[5]);
    bus(1'b1);
    ser(dev(rsa_pkg::GRP_MISC, 1'b0, 1'b1), 1'b0, 1'b0);
    ser(b[4], 1'b1, 1'b1);
    bus(1'b0);
    bus(1'b1);
    ser(dev(rsa_pkg::GRP_MISC, 1'b1, 1'b1), 1'b0, 1'b0);
    ser(b[5], 1'b0, 1'b1);
    ser(8'hff, 1'b1, 1'b1);
    bus(1'b0);
    bus(1'b1);
    ser({~CODE, 4'h2}, 1'b1, 1'b0);
    ser(b[0], 1'b1, 1'b0);
    bus(1'b0);
    axi_wr(rsa_pkg::CTRL_OFS, {28'h0, CODE}, rsa_pkg::RESP_OKAY);
    bus(1'b1);
    ser(dev(rsa_pkg::GRP_STAT, 1'b0, 1'b0), 1'b1, 1'b0);
    bus(1'b0);
    axi_wr(rsa_pkg::CTRL_OFS, {27'h0, 1'b1, CODE}, rsa_pkg::RESP_OKAY);
    bus(1'b1);
    ser(dev(rsa_pkg::GRP_STAT, 1'b0, 1'b0), 1'b0, 1'b0);
    for (int i = 0; i < 4; i++) i_rsa_i2c_master.clk_bit(1'b0, s);
    bus(1'b1);
    ser(dev(rsa_pkg::GRP_STAT, 1'b0, 1'b0), 1'b0, 1'b0);
    ser(b[1], 1'b0, 1'b0);
    bus(1'b0);
    rdb(rsa_pkg::IDX_ST1, b[1]);
    bus(1'b1);
    ser(dev(rsa_pkg::GRP_RTIME, 1'b0, 1'b0), 1'b0, 1'b0);
    ser(b[2], 1'b0, 1'b0);
    bus(1'b0);
    bus(1'b1);
    ser(dev(rsa_pkg::GRP_RTIME, 1'b0, 1'b1), 1'b0, 1'b0);
    ser(b[2], 1'b0, 1'b1);
    ser(8'h00, 1'b1, 1'b1);
    bus(1'b0);
    bus(1'b1);
    ser(dev(rsa_pkg::GRP_INT, 1'b0, 1'b1), 1'b0, 1'b0);
    ser(b[0], 1'b0, 1'b1);
    i_rsa_i2c_master.recover();
    bus(1'b1);
    ser(dev(rsa_pkg::GRP_STAT, 1'b1, 1'b1), 1'b0, 1'b0);
    ser(8'h40, 1'b1, 1'b1);
    bus(1'b0);
    axi_rd(rsa_pkg::STAT_OFS, '0, 34'h0_0000_0041);
    repeat (10) @(posedge sys_clk);
    end_of_test();
  end
endmodule : rtc_serial_access_port_bench
